// ---- psa_panel_setup.sv ----
// Panel meter front-panel scaling, alarm trip and register access logic
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module psa_panel_setup #(
  parameter int unsigned DEBOUNCE_CYCLES = psa_pkg::DEBOUNCE_CYC,
  parameter int unsigned CHORD_CYCLES    = psa_pkg::CHORD_CYC,
  parameter int unsigned COMMIT_CYCLES   = psa_pkg::COMMIT_CYC
) (
  input  wire logic               clock_i,
  input  wire logic               resetn_i,
  input  wire logic               mode_scaling_i,
  input  wire logic               input_kind_switch_i,
  input  wire logic               set_btn_i,
  input  wire logic               enter_btn_i,
  input  wire logic               view_btn_i,
  input  wire logic               alarm_high_jumper_i,
  input  wire logic               alarm_override_i,
  input  wire logic signed [15:0] current_raw_i,
  input  wire logic signed [15:0] voltage_raw_i,
  input  wire logic [5:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output var  logic [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  output var  logic               trip_indicator_lamp_o,
  output var  logic               relay_energize_o,
  output var  psa_pkg::psa_disp_e disp_kind_o,
  output var  logic [15:0]        disp_digits_o,
  output var  logic               flash_en_o,
  output var  logic [1:0]         flash_pos_o,
  output var  logic [3:0]         dp_mask_o,
  output var  logic signed [15:0] meas_value_o
);
  import psa_pkg::*;

  //----------------------------------------
  // Helpers
  //----------------------------------------
  function automatic logic [15:0] step_digit(input logic [15:0] v, input logic [1:0] p);
    logic [3:0]  idx;
    logic [3:0]  d;
    logic [15:0] r;
    idx = {~p, 2'b00};
    r = v;
    d = v[idx +: 4];
    r[idx +: 4] = (d >= DIGIT_MAX) ? 4'h0 : d + 4'h1;
    return r;
  endfunction : step_digit

  function automatic logic [15:0] bcd2bin(input logic [15:0] v);
    return {12'h000, v[15:12]} * 16'h03E8 + {12'h000, v[11:8]} * 16'h0064
         + {12'h000, v[7:4]} * 16'h000A + {12'h000, v[3:0]};
  endfunction : bcd2bin

  //----------------------------------------
  // Button debounce
  //----------------------------------------
  logic [2:0]  btn_raw_w;
  logic [2:0]  deb_q;
  logic [2:0]  prev_q;
  logic [31:0] deb_cnt_q [3];

  assign btn_raw_w = {view_btn_i, enter_btn_i, set_btn_i};

  for (genvar gi = 0; gi < 3; gi++) begin : g_deb
    always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
        deb_cnt_q[gi] <= 32'h0000_0000;
        deb_q[gi]     <= 1'b0;
      end else if (btn_raw_w[gi] == deb_q[gi]) begin
        deb_cnt_q[gi] <= 32'h0000_0000;
      end else if (deb_cnt_q[gi] >= DEBOUNCE_CYCLES - 1) begin
        deb_cnt_q[gi] <= 32'h0000_0000;
        deb_q[gi]     <= btn_raw_w[gi];
      end else begin
        deb_cnt_q[gi] <= deb_cnt_q[gi] + 32'h0000_0001;
      end
    end
  end

  //----------------------------------------
  // Chord detection
  //----------------------------------------
  logic [31:0] win_cnt_q;
  logic        chord_used_q;
  logic        any_held_w;
  logic        in_window_w;
  logic [2:0]  fall_w;
  logic        ev_se_w;
  logic        ev_sv_w;
  logic        ev_set_w;
  logic        ev_enter_w;

  assign any_held_w  = |deb_q;
  assign in_window_w = win_cnt_q < CHORD_CYCLES;
  assign fall_w      = prev_q & ~deb_q;
  assign ev_se_w     = deb_q[BTN_SET] & deb_q[BTN_ENTER] & ~deb_q[BTN_VIEW] & in_window_w & ~chord_used_q;
  assign ev_sv_w     = deb_q[BTN_SET] & deb_q[BTN_VIEW] & ~deb_q[BTN_ENTER] & in_window_w & ~chord_used_q;
  assign ev_set_w    = fall_w[BTN_SET] & ~chord_used_q;
  assign ev_enter_w  = fall_w[BTN_ENTER] & ~chord_used_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q       <= 3'h0;
      win_cnt_q    <= 32'h0000_0000;
      chord_used_q <= 1'b0;
    end else begin
      prev_q       <= deb_q;
      win_cnt_q    <= !any_held_w ? 32'h0000_0000 : (in_window_w ? win_cnt_q + 32'h0000_0001 : win_cnt_q);
      chord_used_q <= any_held_w & (chord_used_q | ev_se_w | ev_sv_w);
    end
  end

  //----------------------------------------
  // Measurement scaling
  //----------------------------------------
  logic signed [15:0] lo_raw_q;
  logic signed [15:0] hi_raw_q;
  logic [15:0]        lo_disp_q;
  logic [15:0]        hi_disp_q;
  logic [15:0]        trip_q;
  logic [1:0]         dp_q;
  logic signed [15:0] raw_sel_w;
  logic signed [16:0] lo_bin_w;
  logic signed [16:0] trip_bin_w;
  logic signed [16:0] dr_w;
  logic signed [16:0] sr_w;
  logic signed [16:0] sd_w;
  logic signed [33:0] prod_w;
  logic signed [33:0] quo_w;
  logic signed [15:0] meas_d_w;

  assign raw_sel_w  = input_kind_switch_i ? current_raw_i : voltage_raw_i;
  assign lo_bin_w   = $signed({1'b0, bcd2bin(lo_disp_q)});
  assign trip_bin_w = $signed({1'b0, bcd2bin(trip_q)});
  assign dr_w       = 17'(raw_sel_w) - 17'(lo_raw_q);
  assign sr_w       = 17'(hi_raw_q) - 17'(lo_raw_q);
  assign sd_w       = $signed({1'b0, bcd2bin(hi_disp_q)}) - lo_bin_w;
  assign prod_w     = 34'(dr_w) * 34'(sd_w);
  assign quo_w      = (sr_w == 17'sh00000) ? 34'sh0 : prod_w / 34'(sr_w);
  assign meas_d_w   = 16'(34'(lo_bin_w) + quo_w);

  //----------------------------------------
  // Alarm
  //----------------------------------------
  logic override_w;
  logic alarm_cond_w;
  logic sw_override_q;

  assign override_w   = alarm_override_i | sw_override_q;
  assign alarm_cond_w = alarm_high_jumper_i ? (17'(meas_value_o) > trip_bin_w)
                                            : (17'(meas_value_o) < trip_bin_w);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meas_value_o          <= 16'sh0000;
      trip_indicator_lamp_o <= 1'b0;
      relay_energize_o      <= 1'b1;
    end else begin
      meas_value_o          <= meas_d_w;
      trip_indicator_lamp_o <= alarm_cond_w & ~override_w;
      if (!override_w) begin
        relay_energize_o <= ~alarm_cond_w;
      end
    end
  end

  //----------------------------------------
  // Panel state machine
  //----------------------------------------
  psa_state_e  state_q;
  psa_state_e  state_d;
  psa_state_e  after_busy_q;
  psa_state_e  after_busy_d;
  logic [15:0] edit_q;
  logic [15:0] edit_d;
  logic [1:0]  pos_q;
  logic [1:0]  pos_d;
  logic [1:0]  dp_edit_q;
  logic [1:0]  dp_edit_d;
  logic [31:0] busy_cnt_q;
  logic        busy_done_w;
  logic        st_lo_w;
  logic        st_hi_w;
  logic        st_dp_w;
  logic        st_trip_w;
  logic        in_scl_state_w;

  assign busy_done_w    = busy_cnt_q >= COMMIT_CYCLES - 1;
  assign in_scl_state_w = (state_q >= PSA_ST_LO_PROMPT) && (state_q <= PSA_ST_ERROR);

  always_comb begin
    state_d      = state_q;
    after_busy_d = after_busy_q;
    edit_d       = edit_q;
    pos_d        = pos_q;
    dp_edit_d    = dp_edit_q;
    st_lo_w      = 1'b0;
    st_hi_w      = 1'b0;
    st_dp_w      = 1'b0;
    st_trip_w    = 1'b0;
    case (state_q)
      PSA_ST_MEASURE, PSA_ST_TRIP_VIEW: begin
        if (mode_scaling_i) begin
          state_d = PSA_ST_LO_PROMPT;
        end else if (ev_sv_w) begin
          state_d = PSA_ST_TRIP_EDIT;
          edit_d  = trip_q;
          pos_d   = 2'h0;
        end else begin
          state_d = deb_q[BTN_VIEW] ? PSA_ST_TRIP_VIEW : PSA_ST_MEASURE;
        end
      end
      PSA_ST_LO_PROMPT, PSA_ST_HI_PROMPT: begin
        if (ev_enter_w) begin
          state_d = (state_q == PSA_ST_LO_PROMPT) ? PSA_ST_LO_EDIT : PSA_ST_HI_EDIT;
          edit_d  = (state_q == PSA_ST_LO_PROMPT) ? lo_disp_q : hi_disp_q;
          pos_d   = 2'h0;
        end
      end
      PSA_ST_LO_EDIT, PSA_ST_HI_EDIT, PSA_ST_TRIP_EDIT: begin
        if (ev_set_w) begin
          edit_d = step_digit(edit_q, pos_q);
        end else if (ev_enter_w) begin
          pos_d = (pos_q == LAST_DIGIT) ? 2'h0 : pos_q + 2'h1;
        end else if (ev_sv_w && state_q == PSA_ST_TRIP_EDIT) begin
          st_trip_w    = 1'b1;
          state_d      = PSA_ST_BUSY;
          after_busy_d = PSA_ST_MEASURE;
        end else if (ev_se_w && state_q != PSA_ST_TRIP_EDIT && pos_q == LAST_DIGIT) begin
          state_d = PSA_ST_BUSY;
          if (state_q == PSA_ST_LO_EDIT) begin
            st_lo_w      = 1'b1;
            after_busy_d = PSA_ST_HI_PROMPT;
          end else if (raw_sel_w == lo_raw_q) begin
            after_busy_d = PSA_ST_ERROR;
          end else begin
            st_hi_w      = 1'b1;
            after_busy_d = PSA_ST_DP_ALL;
          end
        end
      end
      PSA_ST_DP_ALL: begin
        if (ev_enter_w) begin
          state_d   = PSA_ST_DP_SEL;
          dp_edit_d = 2'h0;
        end
      end
      PSA_ST_DP_SEL: begin
        if (ev_set_w) begin
          dp_edit_d = dp_edit_q + 2'h1;
        end else if (ev_se_w) begin
          st_dp_w      = 1'b1;
          state_d      = PSA_ST_BUSY;
          after_busy_d = PSA_ST_LO_PROMPT;
        end
      end
      PSA_ST_BUSY: begin
        if (busy_done_w) begin
          state_d = after_busy_d;
        end
      end
      PSA_ST_ERROR: begin
        if (ev_set_w || ev_enter_w || ev_se_w) begin
          state_d = PSA_ST_LO_PROMPT;
        end
      end
      default: begin
        state_d = PSA_ST_MEASURE;
      end
    endcase
    // Leaving scaling drops any unstored edit
    if (!mode_scaling_i && in_scl_state_w && state_q != PSA_ST_BUSY) begin
      state_d = PSA_ST_MEASURE;
    end else if (mode_scaling_i && state_q == PSA_ST_TRIP_EDIT) begin
      state_d = PSA_ST_LO_PROMPT;
    end else if (!mode_scaling_i && state_q == PSA_ST_BUSY && after_busy_q != PSA_ST_MEASURE && busy_done_w) begin
      state_d = PSA_ST_MEASURE;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q      <= PSA_ST_MEASURE;
      after_busy_q <= PSA_ST_MEASURE;
      edit_q       <= 16'h0000;
      pos_q        <= 2'h0;
      dp_edit_q    <= 2'h0;
      busy_cnt_q   <= 32'h0000_0000;
    end else begin
      state_q      <= state_d;
      after_busy_q <= after_busy_d;
      edit_q       <= edit_d;
      pos_q        <= pos_d;
      dp_edit_q    <= dp_edit_d;
      busy_cnt_q   <= (state_q == PSA_ST_BUSY) ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Stored points keep their value until a combined press replaces them
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lo_disp_q <= RST_LO_DISP;
      hi_disp_q <= RST_HI_DISP;
      lo_raw_q  <= RST_LO_RAW;
      hi_raw_q  <= RST_HI_RAW;
      trip_q    <= RST_TRIP;
      dp_q      <= RST_DP;
    end else begin
      if (st_lo_w) begin
        lo_disp_q <= edit_q;
        lo_raw_q  <= raw_sel_w;
      end
      if (st_hi_w) begin
        hi_disp_q <= edit_q;
        hi_raw_q  <= raw_sel_w;
      end
      if (st_trip_w) begin
        trip_q <= edit_q;
      end
      if (st_dp_w) begin
        dp_q <= dp_edit_q;
      end
    end
  end

  //----------------------------------------
  // Display
  //----------------------------------------
  psa_disp_e   kind_w;
  logic [15:0] digits_w;

  always_comb begin
    kind_w   = PSA_DK_MEAS;
    digits_w = edit_q;
    case (state_q)
      PSA_ST_LO_PROMPT: kind_w = PSA_DK_LO;
      PSA_ST_HI_PROMPT: kind_w = PSA_DK_HI;
      PSA_ST_LO_EDIT, PSA_ST_HI_EDIT, PSA_ST_TRIP_EDIT: kind_w = PSA_DK_VALUE;
      PSA_ST_DP_ALL, PSA_ST_DP_SEL: kind_w = PSA_DK_DP;
      PSA_ST_BUSY: kind_w = PSA_DK_BUSY;
      PSA_ST_ERROR: kind_w = PSA_DK_ERROR;
      PSA_ST_TRIP_VIEW: begin
        kind_w   = PSA_DK_VALUE;
        digits_w = trip_q;
      end
      default: kind_w = PSA_DK_MEAS;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      disp_kind_o   <= PSA_DK_MEAS;
      disp_digits_o <= 16'h0000;
      flash_en_o    <= 1'b0;
      flash_pos_o   <= 2'h0;
      dp_mask_o     <= 4'h0;
    end else begin
      disp_kind_o   <= kind_w;
      disp_digits_o <= digits_w;
      flash_en_o    <= (state_q == PSA_ST_LO_EDIT) || (state_q == PSA_ST_HI_EDIT) || (state_q == PSA_ST_TRIP_EDIT);
      flash_pos_o   <= pos_q;
      dp_mask_o     <= (state_q == PSA_ST_DP_ALL) ? 4'hF :
                       (state_q == PSA_ST_DP_SEL) ? 4'h8 >> dp_edit_q : 4'h8 >> dp_q;
    end
  end

  //----------------------------------------
  // Register bus
  //----------------------------------------
  logic        ack_q;
  logic        req_w;
  logic        wr_ctrl_w;
  logic [31:0] rd_mux_w;

  assign req_w             = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req_w & ~ack_q;
  assign wr_ctrl_w         = avs_write_i & ack_q & avs_byteenable_i[0] & ({avs_address_i[5:2], 2'b00} == REG_CTRL);

  always_comb begin
    rd_mux_w = 32'h0000_0000;
    case ({avs_address_i[5:2], 2'b00})
      REG_CTRL:    rd_mux_w[CTRL_OVR_BIT] = sw_override_q;
      REG_STATUS:  rd_mux_w = {24'h00_0000, input_kind_switch_i, mode_scaling_i, relay_energize_o,
                               trip_indicator_lamp_o, state_q};
      REG_LO_DISP: rd_mux_w = {16'h0000, lo_disp_q};
      REG_HI_DISP: rd_mux_w = {16'h0000, hi_disp_q};
      REG_LO_RAW:  rd_mux_w = {16'h0000, lo_raw_q};
      REG_HI_RAW:  rd_mux_w = {16'h0000, hi_raw_q};
      REG_TRIP:    rd_mux_w = {16'h0000, trip_q};
      REG_DP:      rd_mux_w = {30'h0000_0000, dp_q};
      REG_MEAS:    rd_mux_w = {16'h0000, meas_value_o};
      default:     rd_mux_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q          <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      sw_override_q  <= 1'b0;
    end else begin
      ack_q <= req_w & ~ack_q;
      if (avs_read_i && !ack_q) begin
        avs_readdata_o <= rd_mux_w;
      end
      if (wr_ctrl_w) begin
        sw_override_q <= avs_writedata_i[CTRL_OVR_BIT];
      end
    end
  end

  //----------------------------------------
  // Assertions
  //----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_lamp_on_trip: assert property (alarm_cond_w && !override_w |=> trip_indicator_lamp_o)
    else $error("lamp not lit on alarm");
  a_lamp_dark_ovr: assert property (override_w |=> !trip_indicator_lamp_o)
    else $error("lamp lit under override");
  a_relay_hold_ovr: assert property (override_w |=> relay_energize_o == $past(relay_energize_o))
    else $error("relay moved under override");
  a_relay_drop_trip: assert property (!override_w && alarm_cond_w |=> !relay_energize_o)
    else $error("relay energised on trip");
  a_scale_entry: assert property (state_q == PSA_ST_MEASURE && mode_scaling_i |=> state_q == PSA_ST_LO_PROMPT ##1
                                  disp_kind_o == PSA_DK_LO)
    else $error("low prompt not shown");
  a_no_scale_proc: assert property (!mode_scaling_i && $past(!mode_scaling_i) && state_q != PSA_ST_BUSY
                                    |-> !in_scl_state_w)
    else $error("scaling state outside scaling mode");
  a_digit_step_0: assert property (state_q == PSA_ST_LO_EDIT && ev_set_w && pos_q == 2'h0 && mode_scaling_i
    |=> edit_q[15:12] == (($past(edit_q[15:12]) == 4'h9) ? 4'h0 : $past(edit_q[15:12]) + 4'h1))
    else $error("digit did not step");
  a_enter_advance: assert property (state_q == PSA_ST_HI_EDIT && ev_enter_w && !ev_set_w && mode_scaling_i
                                    |=> pos_q == $past(pos_q) + 2'h1)
    else $error("flash position did not advance");
  a_commit_busy: assert property (state_q == PSA_ST_LO_EDIT && ev_se_w && pos_q == 2'h3 && mode_scaling_i
                                  |=> state_q == PSA_ST_BUSY && lo_disp_q == $past(edit_q))
    else $error("low store not taken");
  a_dp_step: assert property (state_q == PSA_ST_DP_SEL && ev_set_w && mode_scaling_i
                              |=> dp_edit_q == $past(dp_edit_q) + 2'h1 ##1 dp_mask_o == (4'h8 >> $past(dp_edit_q)))
    else $error("decimal point did not move");
  a_view_trip: assert property (state_q == PSA_ST_MEASURE && deb_q[BTN_VIEW] && !mode_scaling_i && !ev_sv_w
                                |=> state_q == PSA_ST_TRIP_VIEW ##1 disp_digits_o == trip_q)
    else $error("trip point not shown while viewing");
  a_trip_keep: assert property (state_q != PSA_ST_TRIP_EDIT |=> trip_q == $past(trip_q))
    else $error("trip changed outside edit");
endmodule : psa_panel_setup
`default_nettype wire

// ---- psa_pkg.sv ----
// Constants, types and register map of the panel scaling and alarm setup block
//
// Summary of operation
// - Mode switch selects normal measuring or scaling calibration behaviour.
// - Input kind switch selects current or voltage input for measuring.
// - Moving the mode switch to scaling shows the low point prompt.
// - Enter at a point prompt shows the stored value, one digit flashing.
// - Each set press during entry steps the flashing digit, wrapping 9 to 0.
// - Enter alone during entry moves flashing to the next digit.
// - Set plus enter on the last digit stores the value for the point.
// - Busy pattern shows during a store, then next prompt, an error or, after a trip store, the measurement.
// - After low point store, high prompt and same digit entry follow.
// - After high point store, all four decimal points are shown.
// - Enter leaves one decimal point; each set moves it one place.
// - Set plus enter stores point position and returns to low prompt.
// - A combined store binds the applied input to the displayed value.
// - Edits not ended by the combined press are dropped; old values stay.
// - Set and enter do nothing for scaling unless in scaling mode.
// - Set or enter clears a shown error message.
// - Jumper picks high or low alarm direction for trip comparison.
// - Alarm lamp lit while alarm condition holds, dark once it clears.
// - Override keeps lamp dark and relay unchanged despite a trip.
// - While view is held the stored trip point is displayed.
// - Set plus view starts trip editing; set scrolls, enter advances.
// - Second set plus view stores trip point; unstored edits are dropped.
// - Releasing view returns the display to the measurement.
// - Relay de-energised while trip exceeded, energised otherwise.
package psa_pkg;
  localparam int unsigned CLK_HZ        = 10000000;
  localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned CHORD_MS      = 150;
  localparam int unsigned COMMIT_MS     = 2000;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned CHORD_CYC     = CHORD_MS * CLK_KHZ;
  localparam int unsigned COMMIT_CYC    = COMMIT_MS * CLK_KHZ;

  localparam int unsigned BTN_SET       = 0;
  localparam int unsigned BTN_ENTER     = 1;
  localparam int unsigned BTN_VIEW      = 2;

  localparam logic [5:0]  REG_CTRL      = 6'h00;
  localparam logic [5:0]  REG_STATUS    = 6'h04;
  localparam logic [5:0]  REG_LO_DISP   = 6'h08;
  localparam logic [5:0]  REG_HI_DISP   = 6'h0C;
  localparam logic [5:0]  REG_LO_RAW    = 6'h10;
  localparam logic [5:0]  REG_HI_RAW    = 6'h14;
  localparam logic [5:0]  REG_TRIP      = 6'h18;
  localparam logic [5:0]  REG_DP        = 6'h1C;
  localparam logic [5:0]  REG_MEAS      = 6'h20;
  localparam int unsigned CTRL_OVR_BIT  = 0;
  localparam int unsigned STAT_LAMP_BIT = 4;
  localparam int unsigned STAT_RLY_BIT  = 5;
  localparam int unsigned STAT_SCL_BIT  = 6;
  localparam int unsigned STAT_KIND_BIT = 7;

  localparam logic [15:0] RST_LO_DISP   = 16'h0000;
  localparam logic [15:0] RST_HI_DISP   = 16'h9999;
  localparam logic [15:0] RST_LO_RAW    = 16'h0000;
  localparam logic [15:0] RST_HI_RAW    = 16'h7FFF;
  localparam logic [15:0] RST_TRIP      = 16'h5000;
  localparam logic [1:0]  RST_DP        = 2'h3;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  localparam logic [1:0]  LAST_DIGIT    = 2'h3;

  typedef enum logic [3:0] {
    PSA_ST_MEASURE   = 4'b0000,
    PSA_ST_LO_PROMPT = 4'b0001,
    PSA_ST_LO_EDIT   = 4'b0010,
    PSA_ST_HI_PROMPT = 4'b0011,
    PSA_ST_HI_EDIT   = 4'b0100,
    PSA_ST_DP_ALL    = 4'b0101,
    PSA_ST_DP_SEL    = 4'b0110,
    PSA_ST_BUSY      = 4'b0111,
    PSA_ST_ERROR     = 4'b1000,
    PSA_ST_TRIP_VIEW = 4'b1001,
    PSA_ST_TRIP_EDIT = 4'b1010
  } psa_state_e;

  typedef enum logic [2:0] {
    PSA_DK_MEAS  = 3'b000,
    PSA_DK_LO    = 3'b001,
    PSA_DK_HI    = 3'b010,
    PSA_DK_VALUE = 3'b011,
    PSA_DK_BUSY  = 3'b100,
    PSA_DK_ERROR = 3'b101,
    PSA_DK_DP    = 3'b110
  } psa_disp_e;
endpackage : psa_pkg

// ---- psa_operator.sv ----
// Operator model driving the front-panel pushbuttons
`timescale 1ns/100ps
`default_nettype none
module psa_operator (
  input  wire logic clock_i,
  output var  logic set_btn_o,
  output var  logic enter_btn_o,
  output var  logic view_btn_o
);
  initial begin
    set_btn_o   = 1'b0;
    enter_btn_o = 1'b0;
    view_btn_o  = 1'b0;
  end
  // Hold a button pattern, bit0 set, bit1 enter, bit2 view
  task automatic drive(input logic [2:0] btn);
    @(posedge clock_i);
    {view_btn_o, enter_btn_o, set_btn_o} <= btn;
  endtask : drive
  // Pressed buttons go down together and rise together
  task automatic press(input logic [2:0] btn);
    drive(btn);
    repeat (8) @(posedge clock_i);
    drive(3'h0);
    repeat (20) @(posedge clock_i);
  endtask : press
endmodule : psa_operator
`default_nettype wire

// ---- psa_panel_setup_tb_top.sv ----
// Self-checking testbench of the panel scaling and alarm setup block
`timescale 1ns/100ps
`default_nettype none
module psa_panel_setup_tb_top;
  import psa_pkg::*;
  logic               clock_i = 1'b0;
  logic               resetn_i = 1'b0;
  logic               mode = 1'b0;
  logic signed [15:0] raw = 16'sh0100;
  logic [5:0]         addr = 6'h00;
  logic               rd = 1'b0;
  logic [31:0]        rdata;
  logic               wreq;
  psa_disp_e          kind;
  logic [15:0]        digits;
  logic               flash;
  logic [1:0]         pos;
  logic [3:0]         dpm;
  logic               kind_sw = 1'b1;
  logic               jmp = 1'b1;
  logic               ovr = 1'b0;
  logic signed [15:0] vraw = 16'sh0000;
  logic               wr = 1'b0;
  logic [31:0]        wdata = 32'h0000_0000;
  logic               lamp;
  logic               relay;
  logic signed [15:0] meas;
  wire logic          set_b, ent_b, view_b;
  int                 n_errors = 0;
  int                 checks_done = 0;
  int                 cycles = 0;
  always #50 clock_i = ~clock_i;
  psa_operator op (.clock_i(clock_i), .set_btn_o(set_b), .enter_btn_o(ent_b), .view_btn_o(view_b));
  psa_panel_setup #(.DEBOUNCE_CYCLES(4), .CHORD_CYCLES(40), .COMMIT_CYCLES(10)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .mode_scaling_i(mode), .input_kind_switch_i(kind_sw),
    .set_btn_i(set_b), .enter_btn_i(ent_b), .view_btn_i(view_b), .alarm_high_jumper_i(jmp),
    .alarm_override_i(ovr), .current_raw_i(raw), .voltage_raw_i(vraw), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .trip_indicator_lamp_o(lamp), .relay_energize_o(relay),
    .disp_kind_o(kind), .disp_digits_o(digits), .flash_en_o(flash), .flash_pos_o(pos),
    .dp_mask_o(dpm), .meas_value_o(meas));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Avalon read: hold until waitrequest is sampled low, take data at that edge
  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    do @(posedge clock_i); while (wreq !== 1'b0);
    d = rdata;
    rd <= 1'b0;
    @(posedge clock_i);
  endtask : bus_rd
  // Avalon write: request held until waitrequest is sampled low
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    do @(posedge clock_i); while (wreq !== 1'b0);
    wr <= 1'b0;
    @(posedge clock_i);
  endtask : bus_wr
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic t_regs();
    logic [31:0] d;
    bus_rd(REG_LO_DISP, d); check(d, {16'h0000, RST_LO_DISP});
    bus_rd(REG_HI_DISP, d); check(d, {16'h0000, RST_HI_DISP});
    bus_rd(REG_TRIP, d);    check(d, {16'h0000, RST_TRIP});
    bus_rd(REG_DP, d);      check(d, {30'h0, RST_DP});
    bus_rd(6'h3C, d);       check(d, 32'h0);
    $display("Register test done");
  endtask : t_regs
  task automatic t_view();
    logic [31:0] d;
    op.drive(3'h4);
    repeat (10) @(posedge clock_i);
    check({29'h0, kind}, {29'h0, PSA_DK_VALUE});
    check({16'h0, digits}, {16'h0, RST_TRIP});
    op.drive(3'h0);
    repeat (12) @(posedge clock_i);
    check({29'h0, kind}, {29'h0, PSA_DK_MEAS});
    op.press(3'h1);
    bus_rd(REG_STATUS, d); check({28'h0, d[3:0]}, {28'h0, PSA_ST_MEASURE});
    $display("View test done");
  endtask : t_view
  task automatic t_alarm();
    logic [31:0] d;
    raw <= RST_HI_RAW;
    repeat (4) @(posedge clock_i);
    check({30'h0, lamp, relay}, 32'h2);
    ovr <= 1'b1;
    raw <= 16'sh0000;
    repeat (4) @(posedge clock_i);
    check({30'h0, lamp, relay}, 32'h0);
    ovr <= 1'b0;
    repeat (4) @(posedge clock_i);
    check({30'h0, lamp, relay}, 32'h1);
    jmp <= 1'b0;
    repeat (4) @(posedge clock_i);
    check({30'h0, lamp, relay}, 32'h2);
    bus_wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge clock_i);
    check({31'h0, lamp}, 32'h0);
    bus_rd(REG_CTRL, d); check(d, 32'h1);
    bus_wr(REG_CTRL, 32'h0);
    jmp     <= 1'b1;
    kind_sw <= 1'b0;
    vraw    <= RST_HI_RAW;
    repeat (4) @(posedge clock_i);
    check({16'h0, meas}, 32'h0000_270F);
    kind_sw <= 1'b1;
    op.press(3'h5);
    check({flash, pos, digits}, {3'b100, RST_TRIP});
    op.press(3'h1);
    op.press(3'h5);
    bus_rd(REG_TRIP, d); check(d, 32'h6000);
    $display("Alarm test done");
  endtask : t_alarm
  task automatic t_scale();
    logic [31:0] d;
    raw  <= 16'sh0100;
    mode <= 1'b1;
    repeat (6) @(posedge clock_i);
    check({29'h0, kind}, {29'h0, PSA_DK_LO});
    op.press(3'h2);
    check({flash, pos, digits}, {3'b100, RST_LO_DISP});
    op.press(3'h1);
    check({16'h0, digits}, 32'h1000);
    repeat (3) op.press(3'h2);
    check({30'h0, pos}, 32'h3);
    op.drive(3'h3);
    repeat (10) @(posedge clock_i);
    check({29'h0, kind}, {29'h0, PSA_DK_BUSY});
    op.drive(3'h0);
    repeat (20) @(posedge clock_i);
    check({29'h0, kind}, {29'h0, PSA_DK_HI});
    bus_rd(REG_LO_DISP, d); check(d, 32'h1000);
    bus_rd(REG_LO_RAW, d);  check(d, 32'h0100);
    op.press(3'h2);
    op.press(3'h1);
    repeat (3) op.press(3'h2);
    raw <= 16'sh0500;
    op.press(3'h3);
    check({28'h0, dpm}, 32'hF);
    bus_rd(REG_HI_DISP, d); check(d, 32'h0999);
    bus_rd(REG_HI_RAW, d);  check(d, 32'h0500);
    op.press(3'h2);
    check({28'h0, dpm}, 32'h8);
    op.press(3'h1);
    check({28'h0, dpm}, 32'h4);
    op.press(3'h3);
    bus_rd(REG_DP, d); check(d, 32'h1);
    op.press(3'h2);
    op.press(3'h1);
    mode <= 1'b0;
    repeat (6) @(posedge clock_i);
    check({29'h0, kind}, {29'h0, PSA_DK_MEAS});
    bus_rd(REG_LO_DISP, d); check(d, 32'h1000);
    $display("Scaling test done");
  endtask : t_scale
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    t_regs();
    t_view();
    t_alarm();
    t_scale();
    end_sim();
  end
endmodule : psa_panel_setup_tb_top
`default_nettype wire
